/* design/apc_port.sv */
// Parallel host port and conversion control of a 12-bit sampling converter.
// Assumes host pins are asynchronous to ref_clk and the converter core
// presents a settled result on conv_result by the last conversion edge.
`timescale 1ns/1ps

// Notes on behaviour
// - Twelve-bit data port; word mode when select pin high, byte mode low.
// - Conversion start falling edge begins conversion; busy high throughout.
// - Conversion start rising before fourteenth clock fall aborts, back to track.
// - Busy falls at end of each conversion, usable as interrupt.
// - Hold on start fall; track again on thirteenth rising clock edge.
// - In automatic power-down modes, start rise begins power-up.
// - Word read presents the twelve-bit code only; shared pin is data bit 8.
// - Byte reads use lines 0-7; shared pin selects high or low byte.
// - Low byte is eight LSBs; high byte is MSBs, channel, zero.
// - Select and read gated as levels; drive while both low.
// - With select and read held low, data valid before busy falls.
// - Word write loads lines 0-11 into the control word.
// - Channel mask register loads fully in one write, any mode.
// - Write data taken on write strobe rise; select and write gated.
// - Two power bits pick one of four modes; reset selects normal.
// - Normal mode stays powered with no power-up wait.
// - Bits 0,1 auto shutdown; bits 1,0 auto standby after conversions.
// - Both bits set powers down at write end until rewritten.
module apc_port
    import apc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire apc_pins_t pins,
    input wire apc_result_t conv_result,
    output logic busy,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic sampler_track,
    output logic powered_up,
    output logic power_mode_high_bit,
    output logic power_mode_low_bit,
    output logic [DATA_W-1:0] control_word,
    output logic [MASK_W-1:0] channel_mask_register
);

    apc_pins_t pin_s;
    apc_pins_t pin_d;
    apc_pins_t next_pin_d;

    // Synchronise every host pin
    apc_sync #(
        .WIDTH($bits(apc_pins_t))
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .async_in(pins),
        .sync_out(pin_s)
    );

    // Third stage feeds edge detection and write data capture, never the first flop
    always_comb begin
        next_pin_d = clk_en ? pin_s : pin_d;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pin_d <= '1;
        end else begin
            pin_d <= next_pin_d;
        end
    end

    // Edge and level decode from the second and third synchroniser stages
    logic start_fall;
    logic start_rise;
    logic cclk_rise;
    logic cclk_fall;
    logic rd_active;
    logic wr_active;
    logic wr_active_d;
    logic wr_done;
    logic hbe;

    assign start_fall = pin_d.conversion_start_n
                        & ~pin_s.conversion_start_n;
    assign start_rise = ~pin_d.conversion_start_n
                        & pin_s.conversion_start_n;
    assign cclk_rise = ~pin_d.conversion_clock_in
                       & pin_s.conversion_clock_in;
    assign cclk_fall = pin_d.conversion_clock_in
                       & ~pin_s.conversion_clock_in;
    assign rd_active = ~pin_s.chip_select_n & ~pin_s.read_n;
    assign wr_active = ~pin_s.chip_select_n & ~pin_s.write_n;
    assign wr_active_d = ~pin_d.chip_select_n & ~pin_d.write_n;
    // Rising edge of the gated write strobe
    assign wr_done = clk_en & wr_active_d & ~wr_active;
    // Data captured one flop behind the strobe; host hold time must
    // cover the synchroniser latency of a few ref_clk periods.
    assign hbe = ~pin_s.word_mode & pin_s.host_data_lines[HBE_POS];

    // Control word, staging byte and mask register
    logic [BYTE_W-1:0] stage;
    logic mask_pending;
    logic [DATA_W-1:0] next_control_word;
    logic [BYTE_W-1:0] next_stage;
    logic [MASK_W-1:0] next_mask;
    logic next_mask_pending;
    logic ctrl_write;
    logic [DATA_W-1:0] wr_word;

    always_comb begin
        next_control_word = control_word;
        next_stage = stage;
        next_mask = channel_mask_register;
        next_mask_pending = mask_pending;
        ctrl_write = 1'b0;
        wr_word = pin_d.host_data_lines;
        if (wr_done) begin
            if (mask_pending) begin
                next_mask = pin_d.host_data_lines[MASK_W-1:0];
                next_mask_pending = 1'b0;
            end else if (pin_d.word_mode) begin
                ctrl_write = 1'b1;
                wr_word = pin_d.host_data_lines;
            end else if (!pin_d.host_data_lines[HBE_POS]) begin
                next_stage = pin_d.host_data_lines[BYTE_W-1:0];
            end else begin
                ctrl_write = 1'b1;
                wr_word = {pin_d.host_data_lines[3:0], stage};
            end
            if (ctrl_write) begin
                next_control_word = wr_word;
                next_mask_pending = wr_word[MASK_LOAD_POS]
                                    & ~wr_word[SEQ_POS];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            control_word <= CTRL_RESET;
            stage <= STAGE_RESET;
            channel_mask_register <= MASK_RESET;
            mask_pending <= 1'b0;
        end else begin
            control_word <= next_control_word;
            stage <= next_stage;
            channel_mask_register <= next_mask;
            mask_pending <= next_mask_pending;
        end
    end

    logic [1:0] pm;
    logic [1:0] new_pm;
    assign pm = {control_word[PM_HIGH_POS], control_word[PM_LOW_POS]};
    assign new_pm = {wr_word[PM_HIGH_POS], wr_word[PM_LOW_POS]};
    assign power_mode_high_bit = pm[1];
    assign power_mode_low_bit = pm[0];

    // Conversion and power sequencing
    apc_conv_state_t cv;
    apc_conv_state_t next_cv;
    apc_power_state_t pw;
    apc_power_state_t next_pw;
    logic [3:0] fall_cnt;
    logic [3:0] rise_cnt;
    logic [3:0] next_fall_cnt;
    logic [3:0] next_rise_cnt;
    apc_result_t result;
    apc_result_t next_result;
    logic auto_down;

    // Auto modes drop power after every completed conversion, not after an abort
    assign auto_down = (pm == PM_AUTO_SHUTDOWN)
                       || (pm == PM_AUTO_STANDBY);

    always_comb begin
        next_cv = cv;
        next_pw = pw;
        next_fall_cnt = fall_cnt;
        next_rise_cnt = rise_cnt;
        next_result = result;
        if (clk_en) begin
            case (cv)
                CV_HOLD: begin
                    // Power-on and power-down both wait here in hold
                    if (start_rise && pw != PW_FULL_OFF) begin
                        next_cv = CV_TRACK;
                        next_pw = PW_ON;
                    end
                end
                CV_TRACK: begin
                    if (start_fall && pw == PW_ON) begin
                        next_cv = CV_CONVERT;
                        next_fall_cnt = EDGE_CNT_RESET;
                        next_rise_cnt = EDGE_CNT_RESET;
                    end
                end
                CV_CONVERT: begin
                    if (cclk_rise && rise_cnt < 4'(TRACK_RISE_EDGE)) begin
                        next_rise_cnt = rise_cnt + 4'h1;
                    end
                    if (cclk_fall
                        && fall_cnt == 4'(CONV_FALL_EDGES - 1)) begin
                        next_cv = CV_LATCH;
                        next_result = conv_result;
                        next_fall_cnt = fall_cnt + 4'h1;
                    end else if (start_rise) begin
                        next_cv = CV_TRACK;
                    end else if (cclk_fall) begin
                        next_fall_cnt = fall_cnt + 4'h1;
                    end
                end
                CV_LATCH: begin
                    // Extra busy cycle lets read data settle first
                    next_cv = CV_SETTLE;
                end
                CV_SETTLE: begin
                    if (auto_down) begin
                        next_cv = CV_HOLD;
                        next_pw = PW_AUTO_DOWN;
                    end else begin
                        next_cv = CV_TRACK;
                    end
                end
                default: begin
                    next_cv = CV_HOLD;
                end
            endcase
            if (ctrl_write) begin
                if (new_pm == PM_FULL_SHUTDOWN) begin
                    next_pw = PW_FULL_OFF;
                    next_cv = CV_HOLD;
                end else if (pw == PW_FULL_OFF) begin
                    next_pw = PW_ON;
                    next_cv = CV_TRACK;
                end else if (new_pm == PM_NORMAL) begin
                    // Leaving an auto mode powers up at once; hold stays
                    // until the next start rise, as after power-on
                    next_pw = PW_ON;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cv <= CV_HOLD;
            pw <= PW_ON;
            fall_cnt <= EDGE_CNT_RESET;
            rise_cnt <= EDGE_CNT_RESET;
            result <= '0;
        end else begin
            cv <= next_cv;
            pw <= next_pw;
            fall_cnt <= next_fall_cnt;
            rise_cnt <= next_rise_cnt;
            result <= next_result;
        end
    end

    // Busy spans conversion plus the latch and settle cycles
    assign busy = (cv == CV_CONVERT) || (cv == CV_LATCH)
                  || (cv == CV_SETTLE);
    // Track resumes mid-conversion once the thirteenth rise is seen
    assign sampler_track = (cv == CV_TRACK)
                           || (busy && rise_cnt == 4'(TRACK_RISE_EDGE));
    assign powered_up = (pw == PW_ON);

    apc_read_fmt u_read_fmt (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .word_mode(pin_s.word_mode),
        .high_byte_enable(hbe),
        .result(result),
        .read_data(data_out)
    );

    // Enable lags the strobes by the synchroniser depth plus one register
    logic oe_n;
    logic next_oe_n;

    always_comb begin
        next_oe_n = clk_en ? ~rd_active : oe_n;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            oe_n <= 1'b1;
        end else begin
            oe_n <= next_oe_n;
        end
    end

    assign data_oe_n = oe_n;

endmodule : apc_port

/* design/apc_pkg.sv */
// Shared constants and carrier types for the parallel conversion port.
// Assumes a single 10 MHz ref_clk domain; all pins arrive asynchronously.
package apc_pkg;

    // Timing
    localparam int REF_CLK_HZ = 10_000_000;
    localparam int CONV_FALL_EDGES = 14;
    localparam int TRACK_RISE_EDGE = 13;

    // Host data port
    localparam int DATA_W = 12;
    localparam int BYTE_W = 8;
    localparam int CHAN_W = 3;
    localparam int MASK_W = 8;
    localparam int HBE_POS = 8;

    // Control word field positions
    localparam int SEQ_POS = 2;
    localparam int MASK_LOAD_POS = 3;
    localparam int PM_LOW_POS = 4;
    localparam int PM_HIGH_POS = 5;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RESET = 12'h000;
    localparam logic [MASK_W-1:0] MASK_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] STAGE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] RESULT_RESET = 12'h000;
    localparam logic [3:0] EDGE_CNT_RESET = 4'h0;

    // Power management codes {high, low}
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_AUTO_SHUTDOWN = 2'h1;
    localparam logic [1:0] PM_AUTO_STANDBY = 2'h2;
    localparam logic [1:0] PM_FULL_SHUTDOWN = 2'h3;

    // Host pins as seen at the package boundary
    typedef struct packed {
        logic conversion_start_n;
        logic chip_select_n;
        logic read_n;
        logic write_n;
        logic word_mode;
        logic conversion_clock_in;
        logic [DATA_W-1:0] host_data_lines;
    } apc_pins_t;

    // Result as handed over by the converter core
    typedef struct packed {
        logic [CHAN_W-1:0] channel;
        logic [DATA_W-1:0] code;
    } apc_result_t;

    typedef enum logic [4:0] {
        CV_HOLD = 5'h01,
        CV_TRACK = 5'h02,
        CV_CONVERT = 5'h04,
        CV_LATCH = 5'h08,
        CV_SETTLE = 5'h10
    } apc_conv_state_t;

    typedef enum logic [2:0] {
        PW_ON = 3'h1,
        PW_AUTO_DOWN = 3'h2,
        PW_FULL_OFF = 3'h4
    } apc_power_state_t;

endpackage : apc_pkg

/* design/apc_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes the bundle bits are independent levels; no bus coherency.
`timescale 1ns/1ps
module apc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_meta = meta;
        next_sync_out = sync_out;
        if (clk_en) begin
            next_meta = async_in;
            next_sync_out = meta;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            meta <= '1;
            sync_out <= '1;
        end else begin
            meta <= next_meta;
            sync_out <= next_sync_out;
        end
    end

endmodule : apc_sync

/* design/apc_read_fmt.sv */
// Read data formatter: word or byte presentation of the held result.
// Assumes mode and byte select are already synchronised.
`timescale 1ns/1ps
module apc_read_fmt
    import apc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic word_mode,
    input wire logic high_byte_enable,
    input wire apc_result_t result,
    output logic [DATA_W-1:0] read_data
);

    logic [DATA_W-1:0] next_read_data;

    always_comb begin
        next_read_data = read_data;
        if (clk_en) begin
            if (word_mode) begin
                next_read_data = result.code;
            end else if (high_byte_enable) begin
                next_read_data = {4'h0, 1'b0, result.channel,
                                  result.code[DATA_W-1:BYTE_W]};
            end else begin
                next_read_data = {4'h0, result.code[BYTE_W-1:0]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            read_data <= RESULT_RESET;
        end else begin
            read_data <= next_read_data;
        end
    end

endmodule : apc_read_fmt

/* sim/apc_port_assertions.sv */
// Checker for the conversion port, bound to apc_port.
// Assumes clk_en drops only while idle; conversion clock below ref_clk/4.
`timescale 1ns/1ps
module apc_port_assertions
    import apc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire apc_pins_t pins,
    input wire apc_result_t conv_result,
    input wire logic busy,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe_n,
    input wire logic sampler_track,
    input wire logic powered_up,
    input wire logic power_mode_high_bit,
    input wire logic power_mode_low_bit,
    input wire logic [DATA_W-1:0] control_word,
    input wire logic [MASK_W-1:0] channel_mask_register
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic last_cclk;
    logic [4:0] falls;
    logic [4:0] next_falls;
    // Raw pin falls; synchroniser lag leaves one fall of slack
    always_comb begin
        next_falls = falls;
        if (!busy)
            next_falls = 5'h00;
        else if (last_cclk && !pins.conversion_clock_in)
            next_falls = falls + 5'h01;
    end
    always_ff @(posedge ref_clk) begin
        last_cclk <= pins.conversion_clock_in;
        falls <= rstn ? next_falls : 5'h00;
    end
    a_pm_bits_map: assert property (
        {power_mode_high_bit, power_mode_low_bit} == control_word[5:4])
        else $error("power bits differ from control word");
    a_oe_after_read: assert property ($fell(data_oe_n) |->
        !$past(pins.chip_select_n | pins.read_n, 2))
        else $error("bus driven without select and read");
    a_oe_release: assert property ($rose(pins.read_n) |->
        ##[1:4] data_oe_n)
        else $error("bus still driven after read release");
    a_busy_cause: assert property ($rose(busy) |->
        !$past(pins.conversion_start_n, 2) && !sampler_track)
        else $error("busy rose without start fall or hold");
    a_conv_length: assert property ($fell(busy) |->
        falls inside {[13:15]} || $past(pins.conversion_start_n, 2))
        else $error("conversion ended at wrong clock count");
    a_busy_bound: assert property (busy |-> falls < 5'h10)
        else $error("busy held too long");
    a_abort_track: assert property (
        $fell(busy) && falls < 5'h0D |-> ##[0:2] sampler_track)
        else $error("abort did not return to track");
    a_write_edge: assert property (
        $changed({control_word, channel_mask_register}) |->
        $past(pins.write_n, 3) && !$past(pins.write_n, 5))
        else $error("register changed without write rise");
    a_full_off: assert property (
        $rose(power_mode_high_bit & power_mode_low_bit) |->
        ##[0:2] !powered_up && !sampler_track)
        else $error("full shutdown not entered");
    a_normal_on: assert property (control_word[5:4] == 2'h0 &&
        $past(control_word[5:4]) == 2'h0 |-> powered_up)
        else $error("normal mode not powered");
    c_conv: cover property ($fell(busy));
    c_write: cover property ($changed(control_word));
    c_read: cover property ($fell(data_oe_n));
endmodule : apc_port_assertions

bind apc_port apc_port_assertions chk_u (.ref_clk(ref_clk), .rstn(rstn),
    .clk_en(clk_en), .pins(pins), .conv_result(conv_result), .busy(busy),
    .data_out(data_out), .data_oe_n(data_oe_n),
    .sampler_track(sampler_track), .powered_up(powered_up),
    .power_mode_high_bit(power_mode_high_bit),
    .power_mode_low_bit(power_mode_low_bit), .control_word(control_word),
    .channel_mask_register(channel_mask_register));

/* sim/apc_host_model.sv */
// Host bus model driving the conversion port pins like a DSP.
// Assumes its tasks are called from one bench process only.
`timescale 1ns/1ps
module apc_host_model
    import apc_pkg::*;
(
    input wire logic ref_clk,
    output apc_pins_t pins
);
    logic cv_n = 1'b0;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic wm = 1'b1;
    logic cclk = 1'b0;
    logic [1:0] div = 2'h0;
    logic [DATA_W-1:0] dl = 12'h000;
    assign pins = {cv_n, cs_n, rd_n, wr_n, wm, cclk, dl};
    // Free-running at ref_clk/8, inside the sampling limit
    always @(posedge ref_clk) begin
        div <= div + 2'h1;
        if (div == 2'h3)
            cclk <= ~cclk;
    end
    task automatic edge_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : edge_n
    task automatic set_mode(input logic w);
        @(posedge ref_clk) wm <= w;
    endtask : set_mode
    // Five edges each side so the two-flop path sees the strobe
    task automatic wr(input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        dl <= d;
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        edge_n(5);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        edge_n(5);
        dl <= ~d;
    endtask : wr
    task automatic rd(input logic on, input logic hbe);
        @(posedge ref_clk);
        cs_n <= !on;
        rd_n <= !on;
        dl[HBE_POS] <= hbe;
    endtask : rd
    // Rise then acquisition wait; fall only once previous ended
    task automatic start(input logic lvl);
        @(posedge ref_clk) cv_n <= lvl;
        if (lvl)
            edge_n(3);
    endtask : start
endmodule : apc_host_model

/* sim/tb_top.sv */
// Self-checking bench for apc_port with a host bus model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module tb_top
    import apc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    apc_result_t conv_result = {3'h5, 12'hABC};
    apc_pins_t pins;
    logic busy, oe_n, trk, pwr, pmh, pml;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] ctrl;
    logic [MASK_W-1:0] mask;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    always #50 ref_clk = ~ref_clk;
    apc_host_model host_u (.ref_clk(ref_clk), .pins(pins));
    apc_port dut_u (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
        .pins(pins), .conv_result(conv_result), .busy(busy),
        .data_out(dout), .data_oe_n(oe_n), .sampler_track(trk),
        .powered_up(pwr), .power_mode_high_bit(pmh),
        .power_mode_low_bit(pml), .control_word(ctrl),
        .channel_mask_register(mask));
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            $display("FAIL %0t timeout", $time);
            close_out();
        end
    end
    task automatic chk_w(input logic [11:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_w
    task automatic chk_b(input logic got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask : chk_b
    task automatic wait_busy(input logic v, input int lim);
        int n = 0;
        while (busy !== v && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        chk_b(busy, v, "busy wait");
    endtask : wait_busy
    task automatic t_writes;
        host_u.wr(12'hE61);
        chk_w(ctrl, 12'hE61, "word write");
        chk_b(pmh & !pml, 1'b1, "power bits");
        host_u.set_mode(1'b0);
        host_u.wr(12'h02C);
        chk_w(ctrl, 12'hE61, "low byte staged");
        host_u.wr(12'h10A);
        chk_w(ctrl, 12'hA2C, "byte pair");
        host_u.set_mode(1'b1);
        host_u.wr(12'h008);
        host_u.wr(12'h0B6);
        chk_w({4'h0, mask}, 12'h0B6, "word mask");
        chk_w(ctrl, 12'h008, "control kept");
        host_u.set_mode(1'b0);
        host_u.wr(12'h008);
        host_u.wr(12'h100);
        host_u.wr(12'h05A);
        chk_w({4'h0, mask}, 12'h05A, "byte mask");
        host_u.set_mode(1'b1);
    endtask : t_writes
    task automatic t_convert;
        host_u.start(1'b1);
        host_u.edge_n(1);
        chk_b(trk, 1'b1, "track after rise");
        host_u.rd(1'b1, 1'b0);
        host_u.start(1'b0);
        wait_busy(1'b1, 10);
        chk_b(trk, 1'b0, "hold");
        wait_busy(1'b0, 200);
        chk_w(dout, 12'hABC, "word result");
        chk_b(oe_n, 1'b0, "bus driven");
        chk_b(trk, 1'b1, "track at end");
        host_u.start(1'b1);
        host_u.set_mode(1'b0);
        host_u.edge_n(5);
        chk_w(dout, 12'h0BC, "low byte");
        host_u.rd(1'b1, 1'b1);
        host_u.edge_n(5);
        chk_w(dout, 12'h05A, "high byte");
        host_u.rd(1'b0, 1'b0);
        host_u.edge_n(5);
        chk_b(oe_n, 1'b1, "bus released");
        host_u.set_mode(1'b1);
    endtask : t_convert
    task automatic t_abort;
        host_u.start(1'b0);
        wait_busy(1'b1, 10);
        host_u.edge_n(40);
        host_u.start(1'b1);
        wait_busy(1'b0, 5);
        host_u.edge_n(2);
        chk_b(trk, 1'b1, "abort track");
    endtask : t_abort
    task automatic t_auto(input logic [11:0] code);
        host_u.wr(code);
        host_u.start(1'b0);
        wait_busy(1'b1, 10);
        wait_busy(1'b0, 200);
        host_u.edge_n(2);
        chk_b(pwr, 1'b0, "auto power down");
        chk_b(trk, 1'b0, "auto hold");
        host_u.start(1'b1);
        host_u.edge_n(3);
        chk_b(pwr, 1'b1, "power up on rise");
        chk_b(trk, 1'b1, "track on rise");
    endtask : t_auto
    task automatic t_freeze;
        @(posedge ref_clk);
        conv_result <= {3'h2, 12'h4D7};
        clk_en <= 1'b0;
        host_u.start(1'b0);
        host_u.edge_n(8);
        chk_b(busy, 1'b0, "no start while frozen");
        @(posedge ref_clk) clk_en <= 1'b1;
        wait_busy(1'b1, 10);
        wait_busy(1'b0, 200);
        chk_w(dout, 12'h4D7, "second result");
        host_u.wr(12'h000);
        chk_b(pwr, 1'b1, "normal on write");
        host_u.start(1'b1);
        host_u.edge_n(1);
        chk_b(trk, 1'b1, "track after wake");
    endtask : t_freeze
    task automatic t_full;
        host_u.wr(12'h030);
        chk_b(pwr, 1'b0, "full off");
        host_u.start(1'b0);
        host_u.edge_n(8);
        chk_b(busy, 1'b0, "no conversion when off");
        host_u.start(1'b1);
        host_u.wr(12'h000);
        host_u.edge_n(2);
        chk_b(pwr, 1'b1, "normal powered");
        chk_b(trk, 1'b1, "normal track");
    endtask : t_full
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        chk_w(ctrl, CTRL_RESET, "reset control");
        chk_b(pwr, 1'b1, "reset powered");
        chk_b(oe_n, 1'b1, "reset bus");
        t_writes();
        t_convert();
        t_abort();
        t_auto(12'h010);
        t_auto(12'h020);
        t_freeze();
        t_full();
        close_out();
    end
endmodule : tb_top
